// >>> include/scsi_cfg.svh
// Offsets, field positions, reset values and counts for the SCSI
// configuration block. Assumes a 32-bit classic Wishbone register bus.
`ifndef SCSI_CFG_SVH
`define SCSI_CFG_SVH
// Register indices; byte address is four times the index
`define IDX_CTL_ONE    6'h01
`define IDX_INT_EN     6'h03
`define IDX_OWN_ID     6'h04
`define IDX_SYNC_XFER  6'h05
`define IDX_OUT_LATCH  6'h06
`define IDX_OUT_CTL    6'h07
`define IDX_DMA_CTL    6'h10
`define IDX_STATUS     6'h11
`define IDX_TEST_CTL   6'h12
`define IDX_TEST_READ  6'h13
// Field positions
`define IEN_DISC       2
`define IEN_RST        1
`define IEN_PARITY     0
`define XF_HALT_DIS    7
`define XF_PER_HI      6
`define XF_PER_LO      4
`define XF_OFS_HI      3
`define CTL1_EXTRA     7
`define CTL1_DRIVE     6
`define DMA_CLK_HI     7
`define DMA_CLK_LO     6
// Reset values
`define RST_BYTE       8'h00
// Protocol figures
`define MSG_DISCONNECT 8'h04
`define MSG_CMD_DONE   8'h00
`define MAX_OFFSET     4'h8
`define BASE_PERIOD    4'h4
`define EXTRA_BYTES    2'h3
`define FIFO_AW        3
`endif

// >>> include/scsi_pkg.sv
// Types shared by the SCSI configuration block, its peer model and bench.
// Assumes scsi_cfg.svh holds every number.
package scsi_pkg;
  typedef enum logic [2:0] {
    ST_RUN   = 3'b001,
    ST_DRAIN = 3'b010,
    ST_HALT  = 3'b100
  } halt_state_t;
  // Pins and engine status seen by the block
  typedef struct packed {
    logic       initiator;
    logic       scriptMode;
    logic       disconnect;
    logic [7:0] lastMsg;
    logic       rstSeen;
    logic       parityErr;
    logic       xferDone;
    logic       phaseChange;
    logic       atn;
    logic       io;
    logic       dataPhase;
    logic       sending;
    logic       xferActive;
    logic       xferStart;
    logic       byteMoved;
    logic [3:0] offsetLeft;
    logic       fifosEmpty;
    logic       passParity;
    logic       outParityBad;
    logic       selActive;
    logic [7:0] selIds;
    logic       sendLoad;
    logic [7:0] sendByte;
  } bus_in_t;
  // Drives toward the SCSI bus and the transfer engine
  typedef struct packed {
    logic [7:0] dataOut;
    logic       dataOe;
    logic       selMatch;
    logic [7:0] arbId;
    logic       syncMode;
    logic       syncStrobe;
    logic       halted;
    logic       drainAllow;
    logic       flushFifos;
  } bus_out_t;
endpackage : scsi_pkg

// >>> core/fifo_test_mem.sv
// Small storage for the synchronous data FIFO test path.
// Assumes one clock; read data is registered.
`timescale 1ns/10ps
`include "scsi_cfg.svh"
module fifo_test_mem
(
  input  wire logic                   clk,
  input  wire logic                   wrEn,
  input  wire logic [`FIFO_AW-1:0]    wrAddr,
  input  wire logic [7:0]             wrData,
  input  wire logic [`FIFO_AW-1:0]    rdAddr,
  output logic      [7:0]             rdData
);
  logic [7:0] mem [0:(1<<`FIFO_AW)-1];

  // Write and registered read; no reset, contents are test data
  always_ff @(posedge clk)
  begin
    if (wrEn)
    begin
      mem[wrAddr] <= wrData;
    end
    rdData <= mem[rdAddr];
  end
endmodule : fifo_test_mem

// >>> core/scsi_id_sync_xfer_config.sv
// SCSI own-ID, sync transfer, output latch and error enable logic.
// Assumes a 32-bit classic Wishbone master and synchronous inputs.
// Notes on behaviour
// [RULE1] Unexpected disconnect raises interrupt only in initiator role.
// [RULE2] Script mode: disconnect legal only after message 04h or 00h.
// [RULE3] Low-level mode: every disconnect counts as unexpected.
// [RULE4] Bus reset seen raises interrupt when its enable is set.
// [RULE5] Initiator parity interrupt waits for transfer end or phase change.
// [RULE6] Target parity interrupt is raised at once.
// [RULE7] After a fault up to three bytes move; receive FIFOs are flushed.
// [RULE8] Target sending with pass parity never drives a bad byte.
// [RULE9] Sync halt waits until no offset is outstanding.
// [RULE10] Selection answered for every ID bit set in own ID.
// [RULE11] Arbitration uses only the highest set own ID bit.
// [RULE12] Halt-disable clear: halt on parity, and on ATN as target.
// [RULE13] Halt-disable set: transfer continues through ATN or parity.
// [RULE14] Period field bits 6..4 give extension 0 to 7.
// [RULE15] Period is 4 plus extension core cycles; send may add one.
// [RULE16] Core cycle is clock times 2, 1.5 or 1 by DMA bits 7..6.
// [RULE17] Offset field 0 is async, 1..8 offsets, above 8 reserved.
// [RULE18] Sync offset used only in data phases.
// [RULE19] Output latch drives data lines when assert bit is set.
// [RULE20] Outgoing data passes the latch; test writes load the FIFO.
// [RULE21] Each condition has its own enable gating the interrupt.
// [RULE22] Latch drives only with I/O low as initiator, high as target.
//
// The implementer's own choice: the Wishbone interface to the registers.
`timescale 1ns/10ps
`include "scsi_cfg.svh"
module scsi_id_sync_xfer_config
  import scsi_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  output logic             irqReq,
  input  wire bus_in_t     busIn,
  output bus_out_t         busOut
);

  // ******************************************************
  // State
  // ******************************************************
  typedef struct packed {
    logic          ack;
    logic [31:0]   rdData;
    logic [7:0]    ownId;
    logic [7:0]    syncXfer;
    logic [7:0]    outLatch;
    logic [7:0]    outCtl;
    logic [7:0]    ctlOne;
    logic [7:0]    intEn;
    logic [7:0]    dmaCtl;
    logic          testMode;
    logic [2:0]    pend;
    logic          parityDeferred;
    logic          irq;
    halt_state_t   st;
    logic [1:0]    extra;
    logic [1:0]    div;
    logic [3:0]    perCnt;
    logic [`FIFO_AW-1:0] wrPtr;
    logic [`FIFO_AW-1:0] rdPtr;
    bus_out_t      out;
  } blk_state_t;

  blk_state_t s_q;
  blk_state_t s_d;
  logic [7:0] memRdData;
  logic       memWr;

  // Highest set bit as a one-hot code
  function automatic logic [7:0] topBit(input logic [7:0] v);
    topBit = 8'h00;
    for (int i = 0; i < 8; i++)
    begin
      if (v[i])
      begin
        topBit = 8'h01 << i;
      end
    end
  endfunction : topBit

  // ******************************************************
  // Test FIFO storage
  // ******************************************************
  fifo_test_mem uMem (
    .clk    (clk),
    .wrEn   (memWr),
    .wrAddr (s_q.wrPtr),
    .wrData (dat_i[7:0]),
    .rdAddr (s_q.rdPtr),
    .rdData (memRdData)
  );

  // ******************************************************
  // Next-state logic
  // ******************************************************
  logic       wbHit;
  logic       wrLow;
  logic [5:0] idx;
  logic       discEvt;
  logic       parityNow;
  logic       haltTrig;
  logic       coreEn;
  logic [3:0] period;
  logic [3:0] maxOfs;
  logic [2:0] setBits;
  logic [2:0] clrBits;

  always_comb
  begin
    s_d     = s_q;
    wbHit   = cyc_i & stb_i & ~s_q.ack;
    wrLow   = wbHit & we_i & sel_i[0];
    idx     = adr_i[7:2];
    memWr   = 1'b0;
    clrBits = 3'h0;
    s_d.ack = wbHit;
    s_d.out.syncStrobe = 1'b0;

    // Register writes
    if (wrLow)
    begin
      case (idx)
        `IDX_CTL_ONE:   s_d.ctlOne   = dat_i[7:0];
        `IDX_INT_EN:    s_d.intEn    = dat_i[7:0];
        `IDX_OWN_ID:    s_d.ownId    = dat_i[7:0];
        `IDX_SYNC_XFER: s_d.syncXfer = dat_i[7:0];
        `IDX_OUT_LATCH:
        begin
          s_d.outLatch = dat_i[7:0];
          memWr = s_q.testMode;                        // RULE20
        end
        `IDX_OUT_CTL:   s_d.outCtl   = dat_i[7:0];
        `IDX_DMA_CTL:   s_d.dmaCtl   = dat_i[7:0];
        `IDX_STATUS:    clrBits      = dat_i[2:0];
        `IDX_TEST_CTL:  s_d.testMode = dat_i[0];
        default:        clrBits      = 3'h0;
      endcase
    end
    if (memWr)
    begin
      s_d.wrPtr = s_q.wrPtr + 1'b1;
    end

    // Register reads; unmapped indices answer zero
    s_d.rdData = 32'h0000_0000;
    if (wbHit & ~we_i)
    begin
      case (idx)
        `IDX_CTL_ONE:   s_d.rdData[7:0] = s_q.ctlOne;
        `IDX_INT_EN:    s_d.rdData[7:0] = s_q.intEn;
        `IDX_OWN_ID:    s_d.rdData[7:0] = s_q.ownId;
        `IDX_SYNC_XFER: s_d.rdData[7:0] = s_q.syncXfer;
        `IDX_OUT_LATCH: s_d.rdData[7:0] = s_q.outLatch;
        `IDX_OUT_CTL:   s_d.rdData[7:0] = s_q.outCtl;
        `IDX_DMA_CTL:   s_d.rdData[7:0] = s_q.dmaCtl;
        `IDX_STATUS:
          s_d.rdData[7:0] = {2'h0, s_q.st == ST_HALT,
                             s_q.parityDeferred, s_q.irq, s_q.pend};
        `IDX_TEST_CTL:  s_d.rdData[0]   = s_q.testMode;
        `IDX_TEST_READ:
        begin
          s_d.rdData[7:0] = memRdData;
          s_d.rdPtr = s_q.rdPtr + 1'b1;
        end
        default:        s_d.rdData      = 32'h0000_0000;
      endcase
    end

    // Engine sends always pass through the latch
    if (busIn.sendLoad)
    begin
      s_d.outLatch = busIn.sendByte;                   // RULE20
    end

    // Error events; a set in the same cycle beats a clear
    discEvt = busIn.disconnect & busIn.initiator &     // RULE1
              (~busIn.scriptMode |                     // RULE3
               (busIn.lastMsg != `MSG_DISCONNECT &&
                busIn.lastMsg != `MSG_CMD_DONE));      // RULE2
    parityNow = 1'b0;
    if (busIn.parityErr & ~busIn.initiator)
    begin
      parityNow = 1'b1;                                // RULE6
    end
    if (busIn.parityErr & busIn.initiator)
    begin
      s_d.parityDeferred = 1'b1;                       // RULE5
    end
    if (s_q.parityDeferred & (busIn.xferDone | busIn.phaseChange))
    begin
      parityNow = 1'b1;                                // RULE5
      s_d.parityDeferred = 1'b0;
    end
    setBits = {discEvt, busIn.rstSeen, parityNow};     // RULE4
    s_d.pend = (s_q.pend & ~clrBits) | setBits;
    s_d.irq  = |(s_d.pend & {s_d.intEn[`IEN_DISC],
                             s_d.intEn[`IEN_RST],
                             s_d.intEn[`IEN_PARITY]}); // RULE21

    // Halt control
    haltTrig = ~s_q.syncXfer[`XF_HALT_DIS] &           // RULE13
               (busIn.parityErr |
                (~busIn.initiator & busIn.atn));       // RULE12
    case (s_q.st)
      ST_RUN:
      begin
        if (busIn.xferActive & haltTrig)
        begin
          s_d.st    = ST_DRAIN;
          s_d.extra = 2'h0;
        end
      end
      ST_DRAIN:
      begin
        if (busIn.byteMoved && s_q.extra != `EXTRA_BYTES)
        begin
          s_d.extra = s_q.extra + 1'b1;                // RULE7
        end
        if (busIn.offsetLeft == 4'h0 &&
            (busIn.sending | busIn.fifosEmpty))
        begin
          s_d.st = ST_HALT;                            // RULE9
        end
      end
      ST_HALT:
      begin
        if (busIn.xferStart)
        begin
          s_d.st = ST_RUN;
        end
      end
      default: s_d.st = ST_RUN;
    endcase

    // Core cycle enable from the clock divider
    coreEn = 1'b0;
    case (s_q.dmaCtl[`DMA_CLK_HI:`DMA_CLK_LO])
      2'b10: coreEn = 1'b1;                            // RULE16
      2'b01:
      begin
        s_d.div = (s_q.div == 2'h2) ? 2'h0 : s_q.div + 1'b1;
        coreEn  = (s_q.div != 2'h0);                   // RULE16
      end
      default:
      begin
        s_d.div = {1'b0, ~s_q.div[0]};
        coreEn  = s_q.div[0];                          // RULE16
      end
    endcase

    // Sync period and offset
    period = `BASE_PERIOD +
             {1'b0, s_q.syncXfer[`XF_PER_HI:`XF_PER_LO]}; // RULE14
    if (busIn.sending & s_q.ctlOne[`CTL1_EXTRA])
    begin
      period = period + 4'h1;                          // RULE15
    end
    maxOfs = s_q.syncXfer[`XF_OFS_HI:0];
    if (maxOfs > `MAX_OFFSET)
    begin
      maxOfs = 4'h0;                                   // RULE17
    end
    s_d.out.syncMode = busIn.dataPhase &&
                       maxOfs != 4'h0;                 // RULE18
    if (~(s_d.out.syncMode & busIn.xferActive))
    begin
      s_d.perCnt = 4'h0;
    end
    else if (coreEn)
    begin
      if (s_q.perCnt == period - 4'h1)
      begin
        s_d.perCnt = 4'h0;
        s_d.out.syncStrobe = 1'b1;                     // RULE15
      end
      else
      begin
        s_d.perCnt = s_q.perCnt + 4'h1;
      end
    end

    // Bus-side outputs
    s_d.out.dataOut    = s_d.outLatch;                 // RULE19
    s_d.out.dataOe     = s_d.ctlOne[`CTL1_DRIVE] &
                         (busIn.initiator ? ~busIn.io
                                          : busIn.io) & // RULE22
                         ~(~busIn.initiator & busIn.passParity &
                           busIn.outParityBad);        // RULE8
    s_d.out.selMatch   = busIn.selActive &
                         |(s_q.ownId & busIn.selIds);  // RULE10
    s_d.out.arbId      = topBit(s_q.ownId);            // RULE11
    s_d.out.halted     = (s_d.st == ST_HALT);
    s_d.out.drainAllow = (s_d.st != ST_DRAIN) ||
                         (s_d.extra != `EXTRA_BYTES);  // RULE7
    s_d.out.flushFifos = (s_d.st == ST_DRAIN) &
                         ~busIn.sending;               // RULE7
  end

  // ******************************************************
  // State register
  // ******************************************************
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      s_q    <= '0;
      s_q.st <= ST_RUN;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign ack_o  = s_q.ack;
  assign dat_o  = s_q.rdData;
  assign irqReq = s_q.irq;
  assign busOut = s_q.out;

  // ******************************************************
  // Checks
  // ******************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  AST_DISC_TARGET: // RULE1
    assert property (busIn.disconnect & ~busIn.initiator &
                     s_q.pend[2] == 1'b0 & ~wrLow
                     |=> s_q.pend[2] == 1'b0)
    else $error("disconnect in target role flagged");
  AST_DISC_LEGAL: // RULE2
    assert property (busIn.disconnect & busIn.scriptMode &
                     busIn.lastMsg == 8'h04 & s_q.pend[2] == 1'b0
                     |=> s_q.pend[2] == 1'b0)
    else $error("legal disconnect flagged");
  AST_DISC_LOW: // RULE3
    assert property (busIn.disconnect & busIn.initiator &
                     ~busIn.scriptMode |=> s_q.pend[2])
    else $error("low-level disconnect not flagged");
  AST_RST_IRQ: // RULE4
    assert property (busIn.rstSeen & s_q.intEn[1] & ~wrLow
                     |=> irqReq)
    else $error("bus reset gave no interrupt");
  AST_PAR_TARGET: // RULE6
    assert property (busIn.parityErr & ~busIn.initiator
                     |=> s_q.pend[0])
    else $error("target parity not flagged at once");
  AST_IRQ_MASK: // RULE21
    assert property (s_q.intEn[2:0] == 3'h0 |-> ~irqReq)
    else $error("interrupt with all enables clear");
  AST_NO_BAD_BYTE: // RULE8
    assert property (~busIn.initiator & busIn.passParity &
                     busIn.outParityBad |=> ~busOut.dataOe)
    else $error("bad byte driven onto bus");
  AST_HALT_OFFSET: // RULE9
    assert property (s_q.st == ST_DRAIN & busIn.offsetLeft != 4'h0
                     |=> s_q.st == ST_DRAIN)
    else $error("halt with offset outstanding");
  AST_NO_HALT_DIS: // RULE13
    assert property (s_q.st == ST_RUN & s_q.syncXfer[7]
                     |=> s_q.st == ST_RUN)
    else $error("halted while halt disabled");
  AST_SEL_MATCH: // RULE10
    assert property (busIn.selActive & |(s_q.ownId & busIn.selIds)
                     |=> busOut.selMatch)
    else $error("own ID selection ignored");
  AST_ASYNC_PHASE: // RULE18
    assert property (~busIn.dataPhase |=> ~busOut.syncMode)
    else $error("sync mode outside data phase");
  AST_WB_ACK: // implementer's own choice: the Wishbone interface
    assert property (cyc_i & stb_i & ~ack_o |=> ack_o ##1 ~ack_o)
    else $error("bus answer not one cycle");
endmodule : scsi_id_sync_xfer_config

// >>> bench/scsi_peer_model.sv
// Peer on the far side of the SCSI bus: turns event requests into
// one-cycle pulses and shows the data lines as another device sees them.
// Assumes the bench supplies all level signals through levels.
`timescale 1ns/10ps
module scsi_peer_model
  import scsi_pkg::*;
(
  input  wire logic     clk,
  input  wire bus_in_t  levels,
  input  wire bus_out_t devOut,
  output bus_in_t       busIn,
  output logic [7:0]    lineData
);
  bus_in_t    pulseQ = '0;
  logic [7:0] lastQ  = 8'h00;
  // Events ride on top of the levels for exactly one cycle
  assign busIn = levels | pulseQ;
  // Undriven lines show a changing pattern, never a stale copy
  assign lineData = devOut.dataOe ? devOut.dataOut : ~lastQ;
  always @(posedge clk) lastQ <= lineData;
  task automatic fire(input bus_in_t p);
    @(posedge clk) pulseQ <= p;
    @(posedge clk) pulseQ <= '0;
  endtask : fire
endmodule : scsi_peer_model

// >>> bench/testbench.sv
// Self-checking bench for the SCSI configuration block.
// Assumes the peer model makes bus events; registers over Wishbone.
`timescale 1ns/10ps
`include "scsi_cfg.svh"
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin n_errors++; \
  $display("CHECK FAILED %0t got %h exp %h", $time, a, b); end end
module testbench
  import scsi_pkg::*;
;
  typedef struct packed {
    logic [5:0] idx;
    logic [7:0] wd;
    logic [7:0] exp;
  } row_t;
  // Register rows; an unmapped index must read back zero
  localparam row_t ROWS [0:4] = '{'{`IDX_OWN_ID, 8'h84, 8'h84},
    '{`IDX_SYNC_XFER, 8'hA5, 8'hA5}, '{`IDX_OUT_LATCH, 8'h5A, 8'h5A},
    '{`IDX_OUT_CTL, 8'h3C, 8'h3C}, '{6'h20, 8'hFF, 8'h00}};
  // Disconnect cases: initiator, script, expected irq, 0, last message
  localparam logic [11:0] DISC [0:4] = '{12'hC04, 12'hC00, 12'hE12,
    12'hA04, 12'h012};
  logic        clk;
  logic        resetn;
  logic        cyc;
  logic        stb;
  logic        we;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] datW;
  logic [31:0] datR;
  logic        ack;
  logic        irqReq;
  logic [7:0]  rd;
  logic [7:0]  lineData;
  bus_in_t     lv;
  bus_in_t     busIn;
  bus_out_t    busOut;
  int          n_errors;
  int          n_checks;

  scsi_id_sync_xfer_config dut (.clk(clk), .resetn(resetn), .cyc_i(cyc),
    .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(datW),
    .dat_o(datR), .ack_o(ack), .irqReq(irqReq), .busIn(busIn),
    .busOut(busOut));
  scsi_peer_model peer (.clk(clk), .levels(lv), .devOut(busOut),
    .busIn(busIn), .lineData(lineData));

  // ********************************************************************
  // Bus and event tasks
  // ********************************************************************
  // Request is held until ack is sampled; no fixed latency is assumed
  task automatic wb(input logic w, input logic [5:0] idx,
                    input logic [7:0] wd);
    int n;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    datW <= {24'h0, wd};
    @(posedge clk);
    n = 0;
    while (ack !== 1'b1 && n < 20)
    begin
      @(posedge clk);
      n++;
    end
    rd = datR[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    `CHK(n < 20, 1'b1)
  endtask : wb
  task automatic wr(input logic [5:0] idx, input logic [7:0] wd);
    wb(1'b1, idx, wd);
  endtask : wr
  task automatic rdChk(input logic [5:0] idx, input logic [7:0] exp);
    wb(1'b0, idx, 8'h00);
    `CHK(rd, exp)
  endtask : rdChk
  task automatic settle;
    repeat (3) @(posedge clk);
    #1;
  endtask : settle
  task automatic pulse(input int k);
    bus_in_t p;
    p = '0;
    case (k)
      0: p.parityErr = 1'b1;
      1: p.rstSeen = 1'b1;
      2: p.disconnect = 1'b1;
      3: p.xferDone = 1'b1;
      4: p.phaseChange = 1'b1;
      5: p.xferStart = 1'b1;
      default: p.byteMoved = 1'b1;
    endcase
    peer.fire(p);
    settle;
  endtask : pulse
  task automatic clearIrq;
    wr(`IDX_STATUS, 8'h07);
    settle;
  endtask : clearIrq
  // Counts edges from one strobe to the next, both sampled at edges
  task automatic gap(input int exp);
    int n;
    n = 0;
    @(posedge clk);
    while (busOut.syncStrobe !== 1'b1 && n < 100)
    begin
      @(posedge clk);
      n++;
    end
    n = 1;
    @(posedge clk);
    while (busOut.syncStrobe !== 1'b1 && n < 100)
    begin
      @(posedge clk);
      n++;
    end
    `CHK(n, exp)
  endtask : gap
  task automatic give_verdict;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : give_verdict

  // ********************************************************************
  // Clock, watchdog and main sequence
  // ********************************************************************
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Whole run needs well under a thousand cycles; the 30000-cycle limit leaves ample margin
  initial
  begin
    #300000;
    n_errors++;
    give_verdict;
  end
  initial
  begin
    resetn = 1'b0; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 8'h00;
    sel = 4'hF; datW = 32'h0; lv = '0; rd = 8'h00;
    n_errors = 0; n_checks = 0;
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    #1;
    `CHK({ack, irqReq, datR, busOut}, '0)
    rdChk(`IDX_OWN_ID, 8'h00);
    rdChk(`IDX_SYNC_XFER, 8'h00);
    rdChk(`IDX_OUT_LATCH, 8'h00);
    for (int i = 0; i < 5; i++)
    begin
      wr(ROWS[i].idx, ROWS[i].wd);
      rdChk(ROWS[i].idx, ROWS[i].exp);
    end
    `CHK(busOut.arbId, 8'h80)
    @(posedge clk) lv.selActive <= 1'b1;
    lv.selIds <= 8'h04;
    settle;
    `CHK(busOut.selMatch, 1'b1)
    @(posedge clk) lv.selIds <= 8'h08;
    settle;
    `CHK(busOut.selMatch, 1'b0)
    // Bus reset, enabled then masked; pending still shows in status
    wr(`IDX_INT_EN, 8'h02);
    pulse(1);
    `CHK(irqReq, 1'b1)
    clearIrq;
    `CHK(irqReq, 1'b0)
    wr(`IDX_INT_EN, 8'h00);
    pulse(1);
    `CHK(irqReq, 1'b0)
    rdChk(`IDX_STATUS, 8'h02);
    clearIrq;
    // Parity: target at once, initiator only at transfer end or phase
    wr(`IDX_INT_EN, 8'h01);
    pulse(0);
    `CHK(irqReq, 1'b1)
    clearIrq;
    @(posedge clk) lv.initiator <= 1'b1;
    pulse(0);
    `CHK(irqReq, 1'b0)
    pulse(3);
    `CHK(irqReq, 1'b1)
    clearIrq;
    pulse(0);
    pulse(4);
    `CHK(irqReq, 1'b1)
    clearIrq;
    wr(`IDX_INT_EN, 8'h04);
    for (int i = 0; i < 5; i++)
    begin
      @(posedge clk) lv.initiator <= DISC[i][11];
      lv.scriptMode <= DISC[i][10];
      lv.lastMsg <= DISC[i][7:0];
      pulse(2);
      `CHK(irqReq, DISC[i][9])
      clearIrq;
    end
    // Latch drive by role and I/O level, then the assert bit cleared
    wr(`IDX_CTL_ONE, 8'h40);
    for (int i = 0; i < 4; i++)
    begin
      @(posedge clk) lv.initiator <= i[1];
      lv.io <= i[0];
      settle;
      `CHK(busOut.dataOe, i[1] ^ i[0])
      if (i[1] ^ i[0])
        `CHK(lineData, 8'h5A)
    end
    wr(`IDX_CTL_ONE, 8'h00);
    settle;
    `CHK(busOut.dataOe, 1'b0)
    // Target sending a byte with bad parity keeps it off the lines
    wr(`IDX_CTL_ONE, 8'h40);
    @(posedge clk) lv.initiator <= 1'b0;
    lv.io <= 1'b1;
    lv.sending <= 1'b1;
    lv.passParity <= 1'b1;
    lv.outParityBad <= 1'b1;
    settle;
    `CHK(busOut.dataOe, 1'b0)
    wr(`IDX_CTL_ONE, 8'h00);
    @(posedge clk) lv.sending <= 1'b0;
    lv.passParity <= 1'b0;
    lv.outParityBad <= 1'b0;
    // Offset boundaries and data phases only
    wr(`IDX_SYNC_XFER, 8'h08);
    @(posedge clk) lv.dataPhase <= 1'b1;
    settle;
    `CHK(busOut.syncMode, 1'b1)
    @(posedge clk) lv.dataPhase <= 1'b0;
    settle;
    `CHK(busOut.syncMode, 1'b0)
    @(posedge clk) lv.dataPhase <= 1'b1;
    wr(`IDX_SYNC_XFER, 8'h09);
    settle;
    `CHK(busOut.syncMode, 1'b0)
    // Period: (4 + extension) core cycles, core cycle by clock divide
    wr(`IDX_SYNC_XFER, 8'h28);
    wr(`IDX_DMA_CTL, 8'h80);
    @(posedge clk) lv.xferActive <= 1'b1;
    gap(6);
    wr(`IDX_DMA_CTL, 8'h00);
    gap(12);
    wr(`IDX_DMA_CTL, 8'h80);
    wr(`IDX_CTL_ONE, 8'h80);
    @(posedge clk) lv.sending <= 1'b1;
    gap(7);
    wr(`IDX_SYNC_XFER, 8'h78);
    gap(12);
    wr(`IDX_DMA_CTL, 8'h40);
    gap(18);
    wr(`IDX_CTL_ONE, 8'h00);
    // Halt on parity waits for offset; three extra bytes, then stop
    wr(`IDX_SYNC_XFER, 8'h08);
    @(posedge clk) lv.sending <= 1'b0;
    lv.offsetLeft <= 4'h2;
    lv.fifosEmpty <= 1'b1;
    lv.initiator <= 1'b1;
    pulse(0);
    `CHK({busOut.halted, busOut.flushFifos}, 2'b01)
    pulse(6);
    pulse(6);
    `CHK(busOut.drainAllow, 1'b1)
    pulse(6);
    `CHK(busOut.drainAllow, 1'b0)
    @(posedge clk) lv.offsetLeft <= 4'h0;
    settle;
    `CHK(busOut.halted, 1'b1)
    pulse(5);
    @(posedge clk) lv.initiator <= 1'b0;
    lv.atn <= 1'b1;
    settle;
    `CHK(busOut.halted, 1'b1)
    @(posedge clk) lv.atn <= 1'b0;
    pulse(5);
    wr(`IDX_SYNC_XFER, 8'h88);
    pulse(0);
    @(posedge clk) lv.atn <= 1'b1;
    settle;
    `CHK(busOut.halted, 1'b0)
    // Test mode: latch writes also fill the FIFO, read back in order
    wr(`IDX_TEST_CTL, 8'h01);
    wr(`IDX_OUT_LATCH, 8'hC3);
    wr(`IDX_OUT_LATCH, 8'h3C);
    rdChk(`IDX_TEST_READ, 8'hC3);
    rdChk(`IDX_TEST_READ, 8'h3C);
    // Engine byte replaces the latch contents
    @(posedge clk) lv.sendLoad <= 1'b1;
    lv.sendByte <= 8'h96;
    @(posedge clk) lv.sendLoad <= 1'b0;
    rdChk(`IDX_OUT_LATCH, 8'h96);
    // Reset in mid-run brings the registers back to zero
    @(posedge clk) resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    #1;
    `CHK({ack, irqReq, datR}, '0)
    rdChk(`IDX_OWN_ID, 8'h00);
    rdChk(`IDX_SYNC_XFER, 8'h00);
    rdChk(`IDX_OUT_LATCH, 8'h00);
    give_verdict;
  end
endmodule : testbench
